// >>> src/tpc_phase_dec.sv
// Purpose: Two-phase input synchroniser and up/down event decoder
// Assumes: Phase pins are asynchronous to pclk
// Notes:   Outputs are one-cycle pulses; simultaneous A and B edges count per mode terms
`default_nettype none

module tpc_phase_dec import tpc_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Phase pins
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    // Mode select
    input  wire tpc_phmode_e mode,
    // Count events
    output logic             count_up,
    output logic             count_dn
);

    logic a_s1_q, a_s2_q, a_d_q;
    logic b_s1_q, b_s2_q, b_d_q;
    logic a_r, a_f, b_r, b_f;

    // Two-flop synchronisers, then one delay stage for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            a_d_q  <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            b_d_q  <= 1'b0;
        end else begin
            a_s1_q <= phase_a;
            a_s2_q <= a_s1_q;
            a_d_q  <= a_s2_q;
            b_s1_q <= phase_b;
            b_s2_q <= b_s1_q;
            b_d_q  <= b_s2_q;
        end
    end

    // Edges seen only after the second flop
    assign a_r =  a_s2_q & ~a_d_q;
    assign a_f = ~a_s2_q &  a_d_q;
    assign b_r =  b_s2_q & ~b_d_q;
    assign b_f = ~b_s2_q &  b_d_q;

    // Count conditions; A leading B means up
    always_comb begin
        count_up = 1'b0;
        count_dn = 1'b0;
        unique case (mode)
            PH_MODE1: begin
                count_up = (a_r & ~b_s2_q) | (a_f & b_s2_q) | (b_r & a_s2_q) | (b_f & ~a_s2_q);
                count_dn = (a_r & b_s2_q) | (a_f & ~b_s2_q) | (b_r & ~a_s2_q) | (b_f & a_s2_q);
            end
            PH_MODE2: begin
                count_up = a_f & b_s2_q;
                count_dn = a_f & ~b_s2_q;
            end
            PH_MODE3: begin
                count_up = a_f & b_s2_q;
                count_dn = b_f & a_s2_q;
            end
            PH_MODE4: begin
                count_up = a_r & ~b_s2_q;
                count_dn = a_r & b_s2_q;
            end
        endcase
    end

endmodule : tpc_phase_dec

`default_nettype wire

// >>> src/tpc_pkg.sv
// Purpose: Shared constants and types for the PWM mode 2 / phase counting timer
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Offsets, field positions and reset values live here only
`default_nettype none

package tpc_pkg;

    // Sizes
    localparam int NCH = 3;                        // Channels 0..2
    localparam int NGR = 8;                        // General registers, all channels
    localparam int CW  = 16;                       // Counter width
    localparam int AW  = 8;                        // APB address width

    // Register byte offsets
    localparam logic [AW-1:0] ADDR_START = 8'h00;  // Counter run bits
    localparam logic [AW-1:0] ADDR_MODE  = 8'h04;  // PWM2, phase, sync selection
    localparam logic [AW-1:0] ADDR_CCTL0 = 8'h08;  // counter_control, one per channel
    localparam logic [AW-1:0] ADDR_PIO0  = 8'h14;  // pin_io_control, one per channel
    localparam logic [AW-1:0] ADDR_IER0  = 8'h20;  // interrupt_enable_reg, one per channel
    localparam logic [AW-1:0] ADDR_TSR0  = 8'h2C;  // timer_status_reg, one per channel
    localparam logic [AW-1:0] ADDR_CNT0  = 8'h38;  // channel_counter, one per channel
    localparam logic [AW-1:0] ADDR_GR0   = 8'h44;  // general_compare_capture_reg 0..7

    // Mode register fields
    localparam int MODE_PWM2_LSB  = 0;             // [2:0] PWM mode 2 per channel
    localparam int MODE_PHEN_LSB  = 3;             // [4:3] phase counting ch1, ch2
    localparam int MODE_PHS1_LSB  = 5;             // [6:5] phase mode select ch1
    localparam int MODE_PHS2_LSB  = 7;             // [8:7] phase mode select ch2
    localparam int MODE_SYNC_LSB  = 9;             // [11:9] synchronous operation
    localparam int MODE_W         = 12;

    // counter_control fields
    localparam int CCTL_PSC_LSB   = 0;             // [2:0] prescaler_select
    localparam int CCTL_CKEG_LSB  = 3;             // [4:3] clock_edge_select
    localparam int CCTL_CCLR_LSB  = 5;             // [7:5] counter_clear_select
    localparam int CCTL_W         = 8;
    localparam logic [2:0] CCLR_NONE = 3'h0;       // Free running
    localparam logic [2:0] CCLR_SYNC = 3'h5;       // Cleared with the sync group
    // Values 1..4 clear on match of the channel's local register 0..3; channels 1 and 2 have only registers 0..1, so only values 1..2 clear

    // pin_io_control: 4 bits per local register, bit0 initial level, [2:1] action
    localparam int PIO_INIT_BIT   = 0;
    localparam int PIO_ACT_LSB    = 1;
    localparam int PIO_STRIDE     = 4;

    // timer_status_reg / interrupt_enable_reg layout
    localparam int TSR_OVF        = 4;
    localparam int TSR_UNF        = 5;
    localparam int TSR_DIR        = 7;
    localparam int TSR_W          = 6;

    // Reset values
    localparam logic [CW-1:0]     GR_RST   = 16'hFFFF;
    localparam logic [CW-1:0]     CNT_RST  = 16'h0000;
    localparam logic [CW-1:0]     CNT_MAX  = 16'hFFFF;
    localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;

    // Prescaler divider width, taps for /4, /16, /64
    localparam int DIV_W = 6;

    typedef enum logic [1:0] {ACT_KEEP, ACT_LOW, ACT_HIGH, ACT_TOGGLE} tpc_act_e;
    typedef enum logic [1:0] {PH_MODE1, PH_MODE2, PH_MODE3, PH_MODE4} tpc_phmode_e;

endpackage : tpc_pkg

`default_nettype wire

// >>> src/tpc_top.sv
// Purpose: Three-channel 16-bit timer with PWM mode 2 and phase counting
// Assumes: APB slave with zero wait states; pclk 200 MHz
// Notes:   Channels 3 and 4 of the wider unit are not part of this block
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none

module tpc_top import tpc_pkg::*; (
    // APB slave
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Phase inputs
    input  wire logic          ext_clk_phase_a_ch1,
    input  wire logic          ext_clk_phase_b_ch1,
    input  wire logic          ext_clk_phase_a_ch2,
    input  wire logic          ext_clk_phase_b_ch2,
    // Timer output pins
    output logic               ch0_pin_a,
    output logic               ch0_pin_b,
    output logic               ch0_pin_c,
    output logic               ch0_pin_d,
    output logic               ch1_pin_a,
    output logic               ch1_pin_b,
    output logic               ch2_pin_a,
    output logic               ch2_pin_b,
    // Interrupt
    output logic               irq
);

    // Register state
    logic [NCH-1:0]    run_q;
    logic [MODE_W-1:0] mode_q;
    logic [CCTL_W-1:0] cctl_q [NCH];
    logic [15:0]       pio_q  [NCH];
    logic [TSR_W-1:0]  ier_q  [NCH];
    logic [TSR_W-1:0]  tsr_q  [NCH];
    logic [NCH-1:0]    dir_q;
    logic [CW-1:0]     cnt_q  [NCH];
    logic [CW-1:0]     gr_q   [NGR];
    logic [NGR-1:0]    pin_q;
    logic [DIV_W-1:0]  div_q;
    logic [31:0]       rdata_q;
    logic              err_q;

    // Derived signals
    logic [NCH-1:0]    ph_on, up_ev, dn_ev, inc, dec, step;
    logic [NCH-1:0]    clr_loc, clr, sync_on;
    logic [NGR-1:0]    mt, is_per;
    logic [CW-1:0]     per_val [NCH];
    logic [CW-1:0]     sync_per;
    logic              sync_clr;
    logic [31:0]       rd_d;
    logic              err_d;
    logic              wr_en;

    // Channel of a general register: 0..3 ch0, 4..5 ch1, 6..7 ch2
    function automatic int g_ch(input int g);
        return (g < 4) ? 0 : ((g < 6) ? 1 : 2);
    endfunction : g_ch

    // First general register of a channel
    function automatic int g_base(input int c);
        return (c == 0) ? 0 : ((c == 1) ? 4 : 6);
    endfunction : g_base

    // Registers owned by a channel
    function automatic int g_num(input int c);
        return (c == 0) ? 4 : 2;
    endfunction : g_num

    // Word offset inside a block of n registers at base
    function automatic logic in_blk(input logic [AW-1:0] a, input logic [AW-1:0] base, input int n);
        return (a >= base) && (a < base + AW'(4 * n)) && (a[1:0] == 2'b00);
    endfunction : in_blk

    function automatic int blk_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
        return int'((a - base) >> 2);
    endfunction : blk_idx

    // Prescaler tick: /1, /4, /16, /64
    function automatic logic psc_tick(input logic [2:0] sel, input logic [DIV_W-1:0] d);
        case (sel)
            3'h0:    return 1'b1;
            3'h1:    return d[1:0] == 2'b00;
            3'h2:    return d[3:0] == 4'h0;
            default: return d == 6'h00;
        endcase
    endfunction : psc_tick

    // Pin level after a compare action
    function automatic logic apply_act(input tpc_act_e act, input logic cur);
        case (act)
            ACT_LOW:    return 1'b0;
            ACT_HIGH:   return 1'b1;
            ACT_TOGGLE: return ~cur;
            default:    return cur;
        endcase
    endfunction : apply_act

    // Phase decoders; channel 0 has no phase pins
    tpc_phase_dec u_dec1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_a  (ext_clk_phase_a_ch1),
        .phase_b  (ext_clk_phase_b_ch1),
        .mode     (tpc_phmode_e'(mode_q[MODE_PHS1_LSB +: 2])),
        .count_up (up_ev[1]),
        .count_dn (dn_ev[1])
    );

    tpc_phase_dec u_dec2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_a  (ext_clk_phase_a_ch2),
        .phase_b  (ext_clk_phase_b_ch2),
        .mode     (tpc_phmode_e'(mode_q[MODE_PHS2_LSB +: 2])),
        .count_up (up_ev[2]),
        .count_dn (dn_ev[2])
    );

    assign up_ev[0] = 1'b0;
    assign dn_ev[0] = 1'b0;

    // Phase mode exists on channels 1 and 2 only
    assign ph_on   = {mode_q[MODE_PHEN_LSB + 1], mode_q[MODE_PHEN_LSB], 1'b0};
    assign sync_on = mode_q[MODE_SYNC_LSB +: NCH];

    // Count source; phase mode bypasses prescaler and edge select
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            inc[c] = run_q[c] & (ph_on[c] ? up_ev[c]
                                          : psc_tick(cctl_q[c][CCTL_PSC_LSB +: 3], div_q));
            dec[c] = run_q[c] & ph_on[c] & dn_ev[c];
        end
    end
    assign step = inc | dec;

    // Compare match on a count step while counter equals the register
    always_comb begin
        for (int g = 0; g < NGR; g++) begin
            mt[g] = step[g_ch(g)] & (cnt_q[g_ch(g)] == gr_q[g]);
        end
    end

    // Local clear source, period register and its value per channel
    always_comb begin
        logic [2:0] sel;
        sel = CCLR_NONE;
        is_per = '0;
        for (int c = 0; c < NCH; c++) begin
            sel = cctl_q[c][CCTL_CCLR_LSB +: 3];
            clr_loc[c] = 1'b0;
            per_val[c] = GR_RST;
            if (sel != CCLR_NONE && sel != CCLR_SYNC && int'(sel) <= g_num(c)) begin
                clr_loc[c] = mt[g_base(c) + int'(sel) - 1];
                per_val[c] = gr_q[g_base(c) + int'(sel) - 1];
                is_per[g_base(c) + int'(sel) - 1] = 1'b1;
            end
        end
    end
    // Sync group: first member with a local clear owns the period
    always_comb begin
        sync_per = GR_RST;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (sync_on[c] && cctl_q[c][CCTL_CCLR_LSB +: 3] != CCLR_NONE &&
                cctl_q[c][CCTL_CCLR_LSB +: 3] != CCLR_SYNC) begin
                sync_per = per_val[c];
            end
        end
    end
    assign sync_clr = |(clr_loc & sync_on);

    // Own clear, or clear with the sync group
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            clr[c] = clr_loc[c] | (sync_on[c] & sync_clr &
                     (cctl_q[c][CCTL_CCLR_LSB +: 3] == CCLR_SYNC));
        end
    end

    // APB decode; no wait states
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;

    // Read mux; unmapped offsets answer with an error
    always_comb begin
        rd_d  = RD_ZERO;
        err_d = 1'b0;
        if (paddr == ADDR_START) begin
            rd_d[NCH-1:0] = run_q;
        end else if (paddr == ADDR_MODE) begin
            rd_d[MODE_W-1:0] = mode_q;
        end else if (in_blk(paddr, ADDR_CCTL0, NCH)) begin
            rd_d[CCTL_W-1:0] = cctl_q[blk_idx(paddr, ADDR_CCTL0)];
        end else if (in_blk(paddr, ADDR_PIO0, NCH)) begin
            rd_d[15:0] = pio_q[blk_idx(paddr, ADDR_PIO0)];
        end else if (in_blk(paddr, ADDR_IER0, NCH)) begin
            rd_d[TSR_W-1:0] = ier_q[blk_idx(paddr, ADDR_IER0)];
        end else if (in_blk(paddr, ADDR_TSR0, NCH)) begin
            rd_d[TSR_W-1:0] = tsr_q[blk_idx(paddr, ADDR_TSR0)];
            rd_d[TSR_DIR]   = dir_q[blk_idx(paddr, ADDR_TSR0)];
        end else if (in_blk(paddr, ADDR_CNT0, NCH)) begin
            rd_d[CW-1:0] = cnt_q[blk_idx(paddr, ADDR_CNT0)];
        end else if (in_blk(paddr, ADDR_GR0, NGR)) begin
            rd_d[CW-1:0] = gr_q[blk_idx(paddr, ADDR_GR0)];
        end else begin
            err_d = 1'b1;
        end
    end

    // Read data and error caught in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RD_ZERO;
            err_q   <= 1'b0;
        end else if (psel && !penable) begin
            rdata_q <= rd_d;
            err_q   <= err_d;
        end
    end
    assign prdata  = rdata_q;
    assign pslverr = err_q;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q  <= '0;
            mode_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                cctl_q[c] <= '0;
                pio_q[c]  <= '0;
                ier_q[c]  <= '0;
            end
        end else if (wr_en && !err_d) begin
            if (paddr == ADDR_START) begin
                run_q <= pwdata[NCH-1:0];
            end
            if (paddr == ADDR_MODE) begin
                mode_q <= pwdata[MODE_W-1:0];
            end
            for (int c = 0; c < NCH; c++) begin
                if (paddr == ADDR_CCTL0 + AW'(4 * c)) begin
                    cctl_q[c] <= pwdata[CCTL_W-1:0];
                end
                if (paddr == ADDR_PIO0 + AW'(4 * c)) begin
                    pio_q[c] <= pwdata[15:0];
                end
                if (paddr == ADDR_IER0 + AW'(4 * c)) begin
                    ier_q[c] <= pwdata[TSR_W-1:0];
                end
            end
        end
    end

    // General registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NGR; g++) begin
                gr_q[g] <= GR_RST;
            end
        end else if (wr_en) begin
            for (int g = 0; g < NGR; g++) begin
                if (paddr == ADDR_GR0 + AW'(4 * g)) begin
                    gr_q[g] <= pwdata[CW-1:0];
                end
            end
        end
    end

    // Shared prescaler divider, free running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Counters: write beats clear, clear beats count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                cnt_q[c] <= CNT_RST;
            end
            dir_q <= '1;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_en && paddr == ADDR_CNT0 + AW'(4 * c)) begin
                    cnt_q[c] <= pwdata[CW-1:0];
                end else if (clr[c]) begin
                    cnt_q[c] <= CNT_RST;
                end else if (inc[c]) begin
                    cnt_q[c] <= cnt_q[c] + 1'b1;
                end else if (dec[c]) begin
                    cnt_q[c] <= cnt_q[c] - 1'b1;
                end
                // Direction follows the last step; down wins when up and down come in one cycle
                if (dec[c]) begin
                    dir_q[c] <= 1'b0;
                end else if (inc[c]) begin
                    dir_q[c] <= 1'b1;
                end
            end
        end
    end

    // Status flags; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                tsr_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                logic [TSR_W-1:0] set_v, clr_v;
                set_v = '0;
                clr_v = '0;
                for (int l = 0; l < 4; l++) begin
                    if (l < g_num(c)) begin
                        set_v[l] = mt[g_base(c) + l];
                    end
                end
                set_v[TSR_OVF] = inc[c] & ~clr[c] & (cnt_q[c] == CNT_MAX);
                set_v[TSR_UNF] = dec[c] & ~clr[c] & (cnt_q[c] == CNT_RST);
                if (wr_en && paddr == ADDR_TSR0 + AW'(4 * c)) begin
                    clr_v = pwdata[TSR_W-1:0];
                end
                tsr_q[c] <= (tsr_q[c] & ~clr_v) | set_v;
            end
        end
    end

    // Interrupt: any enabled status bit
    always_comb begin
        irq = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            irq = irq | (|(tsr_q[c] & ier_q[c]));
        end
    end

    // Output pins; stopped channels hold their initial level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= '0;
        end else begin
            for (int g = 0; g < NGR; g++) begin
                logic     init_v;
                tpc_act_e act_v;
                logic     pwm2_v;
                int       c;
                int       l;
                c      = g_ch(g);
                l      = g - g_base(c);
                init_v = pio_q[c][l * PIO_STRIDE + PIO_INIT_BIT];
                act_v  = tpc_act_e'(pio_q[c][l * PIO_STRIDE + PIO_ACT_LSB +: 2]);
                pwm2_v = mode_q[MODE_PWM2_LSB + c];
                if (!run_q[c]) begin
                    pin_q[g] <= init_v;
                end else if (pwm2_v) begin
                    if (clr[c] || is_per[g]) begin
                        pin_q[g] <= init_v;
                    end else if (mt[g] && gr_q[g] != ((cctl_q[c][CCTL_CCLR_LSB +: 3] == CCLR_SYNC)
                                                       ? sync_per : per_val[c])) begin
                        pin_q[g] <= apply_act(act_v, pin_q[g]);
                    end
                end else if (mt[g]) begin
                    pin_q[g] <= apply_act(act_v, pin_q[g]);
                end
            end
        end
    end

    // One pin per register, channels 0 to 2 only
    assign ch0_pin_a = pin_q[0];
    assign ch0_pin_b = pin_q[1];
    assign ch0_pin_c = pin_q[2];
    assign ch0_pin_d = pin_q[3];
    assign ch1_pin_a = pin_q[4];
    assign ch1_pin_b = pin_q[5];
    assign ch2_pin_a = pin_q[6];
    assign ch2_pin_b = pin_q[7];

endmodule : tpc_top

`default_nettype wire

// >>> test/timer_pwm2_phase_count_tb.sv
// Purpose: Bench for the timer block
// Assumes: Encoder models drive the phase pins
// Notes:   Expected counts worked out here
`default_nettype none
module timer_pwm2_phase_count_tb import tpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, u;
    logic ch0_pin_a, ch0_pin_b, ch0_pin_c, ch0_pin_d, ch1_pin_a, ch1_pin_b, ch2_pin_a, ch2_pin_b;
    logic ext_clk_phase_a_ch1, ext_clk_phase_b_ch1, ext_clk_phase_a_ch2, ext_clk_phase_b_ch2;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0] stp = 0, dir = 0, q2 = 0;
    int err_total = 0, checked = 0, seed = 32'h9b75fa9c, n, e, m;
    logic [39:0] cfg [13] = '{40'h0C0000001B, 40'h0400000008, 40'h2400000030, 40'h0000000007, 40'h0,
        40'h0400000001, 40'h0800000020, 40'h1400000440, 40'h4400000009, 40'h4800000003, 40'h4C00000009,
        40'h3800000000, 40'h0000000001};
    always #2.5 pclk = ~pclk;
    tpc_top u_dut (.*);
    tpc_encoder u_enc1 (.pclk, .step(stp[0]), .up(dir[0]), .pha(ext_clk_phase_a_ch1), .phb(ext_clk_phase_b_ch1));
    tpc_encoder u_enc2 (.pclk, .step(stp[1]), .up(dir[1]), .pha(ext_clk_phase_a_ch2), .phb(ext_clk_phase_b_ch2));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 9);
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        {psel, penable} <= 2'b00;
        #1;
    endtask : xfer
    task automatic chk(input string s, input logic [31:0] x, g);
        checked++;
        if (x !== g) begin
            err_total++;
            $display("BAD %s exp %h got %h", s, x, g);
        end
    endtask : chk
    // One quarter step, then a quiet cycle
    task automatic step(input int c, input logic up);
        @(posedge pclk);
        stp[c] <= 1'b1;
        dir[c] <= up;
        @(posedge pclk);
        stp[c] <= 1'b0;
    endtask : step
    function automatic int delta(int md, logic [1:0] q, logic up);
        logic [1:0] p = up ? q + 2'h1 : q - 2'h1;
        logic ao = q[1] ^ q[0], bo = q[1], an = p[1] ^ p[0], bn = p[1];
        case (md)
            0: return up ? 1 : -1;
            1: return (ao && !an) ? (bn ? 1 : -1) : 0;
            2: return (ao && !an && bn) ? 1 : (bo && !bn && an) ? -1 : 0;
            default: return (!ao && an) ? (bn ? -1 : 1) : 0;
        endcase
    endfunction : delta
    task automatic finish_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, ADDR_TSR0 + 8'h4, 0);
        chk("tsr1", 32'h80, rd);
        xfer(0, 8'h64, 0);
        chk("hole", 1, pslverr);
        for (m = 0; m < 4; m++) xfer(1, cfg[m][39:32], cfg[m][31:0]);
        n = 1 + $unsigned($random(seed)) % 20;
        repeat (n) step(0, 1);
        repeat (n + 1) step(0, 0);
        repeat (4) @(posedge pclk);
        xfer(0, ADDR_CNT0 + 8'h4, 0);
        chk("cnt1", 32'hFFFF, rd);
        xfer(0, ADDR_TSR0 + 8'h4, 0);
        chk("unf", 32'h20, rd & 32'hB0);
        chk("irq", 1, irq);
        xfer(1, ADDR_IER0 + 8'h4, 32'h10);
        chk("mask", 0, irq);
        xfer(1, ADDR_TSR0 + 8'h4, 32'h20);
        xfer(1, ADDR_IER0 + 8'h4, 32'h30);
        chk("clear", 0, irq);
        step(0, 1);
        repeat (4) @(posedge pclk);
        xfer(0, ADDR_TSR0 + 8'h4, 0);
        chk("ovf", 32'h90, rd & 32'hB0);
        for (m = 0; m < 4; m++) begin
            xfer(1, ADDR_MODE, 32'h10 | m << 7);
            xfer(1, ADDR_CNT0 + 8'h8, 0);
            e = 0;
            repeat (24) begin
                u = $random(seed) % 2 != 0;
                e += delta(m, q2, u);
                q2 = u ? q2 + 2'h1 : q2 - 2'h1;
                step(1, u);
            end
            repeat (4) @(posedge pclk);
            xfer(0, ADDR_CNT0 + 8'h8, 0);
            chk("cnt2", e & 32'hFFFF, rd);
        end
        for (m = 4; m < 13; m++) xfer(1, cfg[m][39:32], cfg[m][31:0]);
        n = 0;
        e = 0;
        repeat (100) begin
            @(posedge pclk);
            n += ch0_pin_b;
            e += ch0_pin_a | ch0_pin_c;
        end
        chk("duty", 60, n);
        chk("flat", 0, e);
        finish_test;
    end
    // Hang guard, far past the few hundred cycles needed
    initial begin
        #100us;
        err_total++;
        finish_test;
    end
endmodule : timer_pwm2_phase_count_tb
`default_nettype wire

// >>> test/tpc_asserts.sv
// Purpose: Port checks for the timer block
// Assumes: Only the top ports are visible
// Notes:   Bound at the foot of this file
`default_nettype none
module tpc_asserts import tpc_pkg::*; (
    // Bus, interrupt and two pins
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ch0_pin_b, ch1_pin_a,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] prdata
);
    logic wr_q;
    wire logic su = psel && !penable;
    // Nothing may wake before software has written once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wr_q <= 1'b0;
        else if (psel && penable && pwrite) wr_q <= 1'b1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    rdata_hold_a: assert property (!su |=> $stable(prdata)) else $error("prdata moved");
    err_hold_a: assert property (!su |=> $stable(pslverr)) else $error("pslverr moved");
    hole_err_a: assert property (su && paddr > 8'h60 |=> pslverr) else $error("no error");
    reg_ok_a: assert property (su && paddr < 8'h61 && paddr[1:0] == 2'h0 |=> !pslverr) else $error("bad err");
    irq_idle_a: assert property (!wr_q |-> !irq) else $error("early irq");
    pin_idle_a: assert property (!wr_q |-> !ch0_pin_b && !ch1_pin_a) else $error("early pin");
    gr_reset_a: assert property (su && !pwrite && paddr == ADDR_GR0 && !wr_q |=> prdata == {16'h0, GR_RST})
        else $error("gr0 reset");
    hole_c: cover property (su && paddr > 8'h60);
    irq_c: cover property ($rose(irq));
    pwm_c: cover property ($rose(ch0_pin_b));
endmodule : tpc_asserts
bind tpc_top tpc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .irq,
    .ch0_pin_b, .ch1_pin_a, .paddr, .prdata);
`default_nettype wire

// >>> test/tpc_encoder.sv
// Purpose: Two-phase encoder model
// Assumes: One quarter step per edge with step set
// Notes:   A leads B going up
`default_nettype none
module tpc_encoder (
    // Control and phases
    input wire logic pclk, step, up,
    output logic     pha, phb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_q = 2'h0;
    // Gray walk, so one phase moves at a time
    always @(posedge pclk) if (step) pos_q <= up ? pos_q + 2'h1 : pos_q - 2'h1;
    assign pha = pos_q[1] ^ pos_q[0];
    assign phb = pos_q[1];
endmodule : tpc_encoder
`default_nettype wire
